// ===== efd_pkg.sv
// Constants and types of the external flash space decoder
package efd_pkg;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int OFF_W = 24;
    localparam int BLK_W = 3;
    localparam logic [7:0] WIN_BLK0 = 8'hf9;
    localparam logic [7:0] WIN_BLK1 = 8'hfa;
    localparam logic [7:0] WIN_BLK2 = 8'hf8;
    localparam logic [7:0] WIN_HIGH_MIN = 8'h03;
    localparam logic [7:0] WIN_HIGH_MAX = 8'h07;
    localparam logic [2:0] BLK_IDX_0 = 3'h0;
    localparam logic [2:0] BLK_IDX_1 = 3'h1;
    localparam logic [2:0] BLK_IDX_2 = 3'h2;
    // ------------------------------------------------------------
    // Chip-select indices, all selects active low
    // ------------------------------------------------------------
    localparam int NUM_SEL = 3;
    localparam int SEL_A = 0;
    localparam int SEL_BOOT = 1;
    localparam int SEL_C = 2;
    localparam logic [2:0] SEL_NONE_B = 3'h7;
    localparam logic [2:0] SEL_ONEHOT_A = 3'h1;
    localparam logic [2:0] SEL_ONEHOT_BOOT = 3'h2;
    localparam logic [2:0] SEL_ONEHOT_C = 3'h4;
    localparam logic [1:0] PROBE_LAST = 2'h2;
    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_VIDEO = 2'h0;
    localparam logic [1:0] MODE_VIDEO_PAT = 2'h1;
    localparam logic [1:0] MODE_PRESTORED = 2'h2;
    localparam logic [1:0] MODE_OTF = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACC_TIME_NS = 250;
    localparam int PROBE_TIME_NS = 500;
    localparam int ACC_CYC = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROBE_CYC = (PROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    typedef enum logic [2:0] {ST_RESET, ST_PROBE, ST_READY, ST_ACCESS, ST_HALT} efd_state_t;
endpackage

// ===== efd_decoder.sv
// External flash space decoder: probe, window decode, chip-select timing
// Operation
// - Three flash selects, each reaching sixteen megabytes behind it.
// - Three extra upper address lines extend external memory access.
// - Boot select is used at power-up; firmware lives behind it.
// - Probe every select at power-up; missing boot memory halts boot.
// - Address windows follow a select order different from numeric.
// - One combined flash up to 128 megabytes is also supported.
// - Blocks 0,1,2 at f9,fa,f8 map to offsets 0,1,2; 3-7 identical.
// - Only pre-stored pattern mode fetches patterns from flash.
// - Bootloader occupies first 128 kilobytes of block 0.
// - Extended address lines serve flash addressing only.
`timescale 1ns/1ns
`default_nettype none
module efd_decoder
    import efd_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic REQ_PATTERN,
    input wire logic [1:0] OP_MODE,
    input wire logic FLASH_PRESENT,
    input wire logic LARGE_FLASH_STRAP,
    output logic FLASH_SELECT_A_B,
    output logic BOOT_FLASH_SELECT_B,
    output logic FLASH_SELECT_C_B,
    output logic [OFF_W-1:0] FLASH_ADDR,
    output logic EXT_ADDR_LINE_A,
    output logic EXT_ADDR_LINE_B,
    output logic EXT_ADDR_LINE_C,
    output logic REQ_ACK,
    output logic REQ_ERR,
    output logic READY,
    output logic BOOT_FAIL,
    output logic [NUM_SEL-1:0] PRESENT_MAP
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] ACC_INIT = CNT_W'(ACC_CYC - 1);
    localparam logic [CNT_W-1:0] PROBE_INIT = CNT_W'(PROBE_CYC - 1);
    localparam int CNT_MAX = (2 ** CNT_W) - 1;
    if (ACC_CYC < 1 || ACC_CYC > CNT_MAX || PROBE_CYC < 1 || PROBE_CYC > CNT_MAX) begin : g_bad_timing
        $error("Timing counts do not fit the counter");
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic pres_s1_q, pres_s2_q, strap_s1_q, strap_s2_q;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pres_s1_q <= 1'b0;
            pres_s2_q <= 1'b0;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            pres_s1_q <= FLASH_PRESENT;
            pres_s2_q <= pres_s1_q;
            strap_s1_q <= LARGE_FLASH_STRAP;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    efd_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] pos_q, pos_d;
    logic [2:0] present_q, present_d, sel_n_q, sel_n_d, ext_q, ext_d;
    logic [OFF_W-1:0] addr_q, addr_d;
    logic large_q, large_d, ack_q, ack_d, err_q, err_d, ready_q, ready_d, fail_q, fail_d;

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    wire [7:0] win = REQ_ADDR[ADDR_W-1:OFF_W];
    wire hit_b0 = (win == WIN_BLK0);
    wire hit_b1 = (win == WIN_BLK1);
    wire hit_b2 = (win == WIN_BLK2);
    // Blocks 3-7 only exist when one large part sits behind combined selects
    wire hit_high = large_q && (win >= WIN_HIGH_MIN) && (win <= WIN_HIGH_MAX);
    wire blk_hit = hit_b0 || hit_b1 || hit_b2 || hit_high;
    wire [2:0] blk_num = hit_b0 ? BLK_IDX_0 : hit_b1 ? BLK_IDX_1 : hit_b2 ? BLK_IDX_2 : win[2:0];
    // Window order f8,f9,fa lands on c, boot, a: not numeric select order
    wire [2:0] dec_sel = hit_b1 ? SEL_ONEHOT_A : hit_b2 ? SEL_ONEHOT_C : SEL_ONEHOT_BOOT;
    // Single large part answers on the boot probe alone
    wire present_ok = large_q ? present_q[SEL_BOOT] : |(dec_sel & present_q);
    wire pat_refused = REQ_PATTERN && (OP_MODE != MODE_PRESTORED);
    wire dec_ok = blk_hit && present_ok && !pat_refused;
    wire take = REQ_VALID && (state_q == ST_READY);
    // Extra lines carry flash offset bits above 16 MB, only in large mode
    wire [2:0] dec_ext = large_q ? blk_num : 3'h0;
    wire [2:0] probe_sel = (pos_q == 2'h0) ? SEL_ONEHOT_BOOT : (pos_q == 2'h1) ? SEL_ONEHOT_A : SEL_ONEHOT_C;
    wire probe_done = (cnt_q == '0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pos_d = pos_q;
        present_d = present_q;
        sel_n_d = sel_n_q;
        ext_d = ext_q;
        addr_d = addr_q;
        large_d = large_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        ready_d = ready_q;
        fail_d = fail_q;
        case (state_q)
            ST_RESET: begin
                // Boot select probed first
                state_d = ST_PROBE;
                pos_d = 2'h0;
                cnt_d = PROBE_INIT;
                sel_n_d = ~SEL_ONEHOT_BOOT;
            end
            ST_PROBE: begin
                if (probe_done) begin
                    present_d = present_q | (probe_sel & {NUM_SEL{pres_s2_q}});
                    sel_n_d = SEL_NONE_B;
                    if (pos_q == 2'h0 && !pres_s2_q) begin
                        state_d = ST_HALT;
                        fail_d = 1'b1;
                    end else if (pos_q == PROBE_LAST) begin
                        // Sync chain is cleared by reset, so the strap is only valid late
                        large_d = strap_s2_q;
                        state_d = ST_READY;
                        ready_d = 1'b1;
                    end else begin
                        pos_d = pos_q + 2'h1;
                        cnt_d = PROBE_INIT;
                        sel_n_d = (pos_q == 2'h0) ? ~SEL_ONEHOT_A : ~SEL_ONEHOT_C;
                    end
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_READY: begin
                if (take && dec_ok) begin
                    state_d = ST_ACCESS;
                    cnt_d = ACC_INIT;
                    sel_n_d = ~dec_sel;
                    addr_d = REQ_ADDR[OFF_W-1:0];
                    ext_d = dec_ext;
                    ready_d = 1'b0;
                end else if (take) begin
                    err_d = 1'b1;
                end
            end
            ST_ACCESS: begin
                if (probe_done) begin
                    sel_n_d = SEL_NONE_B;
                    ack_d = 1'b1;
                    ready_d = 1'b1;
                    state_d = ST_READY;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_HALT: begin
                // Without boot memory nothing else runs until reset
                sel_n_d = SEL_NONE_B;
            end
            default: begin
                state_d = ST_HALT;
                sel_n_d = SEL_NONE_B;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_RESET;
            cnt_q <= '0;
            pos_q <= 2'h0;
            present_q <= 3'h0;
            sel_n_q <= SEL_NONE_B;
            ext_q <= 3'h0;
            addr_q <= '0;
            large_q <= 1'b0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            ready_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            present_q <= present_d;
            sel_n_q <= sel_n_d;
            ext_q <= ext_d;
            addr_q <= addr_d;
            large_q <= large_d;
            ack_q <= ack_d;
            err_q <= err_d;
            ready_q <= ready_d;
            fail_q <= fail_d;
        end
    end

    assign FLASH_SELECT_A_B = sel_n_q[SEL_A];
    assign BOOT_FLASH_SELECT_B = sel_n_q[SEL_BOOT];
    assign FLASH_SELECT_C_B = sel_n_q[SEL_C];
    assign FLASH_ADDR = addr_q;
    assign EXT_ADDR_LINE_A = ext_q[0];
    assign EXT_ADDR_LINE_B = ext_q[1];
    assign EXT_ADDR_LINE_C = ext_q[2];
    assign REQ_ACK = ack_q;
    assign REQ_ERR = err_q;
    assign READY = ready_q;
    assign BOOT_FAIL = fail_q;
    assign PRESENT_MAP = present_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_taken_ok;
        take && dec_ok;
    endsequence
    sequence s_select_held;
        (sel_n_q != SEL_NONE_B)[*3] ##1 (ack_q && sel_n_q == SEL_NONE_B);
    endsequence

    AST_ONE_SELECT: assert property ($onehot0(~sel_n_q))
        else $error("More than one flash select active");
    AST_UNMAPPED_NONE: assert property (take && !blk_hit |=> err_q && sel_n_q == SEL_NONE_B)
        else $error("Unmapped address drove a select");
    AST_ACCESS_LEN: assert property (s_taken_ok |=> s_select_held)
        else $error("Select not held for the access time");
    AST_BOOT_FAIL: assert property (fail_q |-> !ready_q && sel_n_q == SEL_NONE_B)
        else $error("Boot failure still allows accesses");
    AST_BOOT_FIRST: assert property (state_q == ST_RESET |=> !sel_n_q[SEL_BOOT])
        else $error("Boot select not probed first");
    AST_BLK1_TO_A: assert property (s_taken_ok and hit_b1 |=> !sel_n_q[SEL_A]
        && addr_q == $past(REQ_ADDR[OFF_W-1:0]) && ext_q == (large_q ? 3'h1 : 3'h0))
        else $error("Block 1 window decoded wrongly");
    AST_LARGE_EXT: assert property (s_taken_ok and hit_high |=> ext_q == $past(win[2:0]))
        else $error("Extended lines do not carry the block");
    AST_PATTERN_MODE: assert property (take && pat_refused |=> err_q ##1 sel_n_q == SEL_NONE_B)
        else $error("Pattern fetch outside pre-stored mode");
    AST_EXT_SMALL: assert property (!large_q && state_q != ST_RESET |-> ext_q == 3'h0)
        else $error("Extended lines moved without a large flash");
endmodule
`default_nettype wire

// ===== efd_flash_model.sv
// Flash partner model: parts behind the three selects answering presence probes
`timescale 1ns/1ns
`default_nettype none
module efd_flash_model (
    input wire logic ref_clk,
    input wire logic sel_a_b,
    input wire logic sel_boot_b,
    input wire logic sel_c_b,
    input wire logic [2:0] populated,
    output logic present
);
    logic last_q = 1'b0;
    logic [2:0] sel;
    assign sel = ~{sel_c_b, sel_boot_b, sel_a_b};
    // Only a fitted, selected part answers; firmware part sits behind boot select
    assign present = (|sel) ? |(sel & populated) : ~last_q;
    // Released line toggles, so a stale level never looks valid
    always_ff @(posedge ref_clk) begin
        last_q <= present;
    end
endmodule
`default_nettype wire

// ===== efd_decoder_test.sv
// Self-checking testbench of the external flash space decoder
`timescale 1ns/1ns
`default_nettype none
module efd_decoder_test;
    import efd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic req_pattern = 1'b0;
    logic [1:0] op_mode = MODE_VIDEO;
    logic strap = 1'b0;
    logic [2:0] pop = 3'h7;
    logic flash_present, sel_a_b, sel_boot_b, sel_c_b, ext_a, ext_b, ext_c;
    logic req_ack, req_err, ready, boot_fail;
    logic [23:0] flash_addr;
    logic [2:0] present_map;
    int err_total = 0;
    int n_compared = 0;

    efd_decoder efd_decoder_i (.REF_CLK(ref_clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_ADDR(req_addr),
        .REQ_PATTERN(req_pattern), .OP_MODE(op_mode), .FLASH_PRESENT(flash_present), .LARGE_FLASH_STRAP(strap),
        .FLASH_SELECT_A_B(sel_a_b), .BOOT_FLASH_SELECT_B(sel_boot_b), .FLASH_SELECT_C_B(sel_c_b),
        .FLASH_ADDR(flash_addr), .EXT_ADDR_LINE_A(ext_a), .EXT_ADDR_LINE_B(ext_b), .EXT_ADDR_LINE_C(ext_c),
        .REQ_ACK(req_ack), .REQ_ERR(req_err), .READY(ready), .BOOT_FAIL(boot_fail), .PRESENT_MAP(present_map));
    efd_flash_model efd_flash_model_i (.ref_clk(ref_clk), .sel_a_b(sel_a_b), .sel_boot_b(sel_boot_b),
        .sel_c_b(sel_c_b), .populated(pop), .present(flash_present));

    always #50 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Strap held through the whole reset so the sync chain settles
    task automatic do_reset(input logic s, input logic [2:0] p, output int n);
        @(negedge ref_clk);
        rst_b = 1'b0;
        strap = s;
        pop = p;
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        n = 0;
        while (!(ready === 1'b1 || boot_fail === 1'b1) && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic do_req(input logic [31:0] a, input logic p, input logic [2:0] es, input logic ee,
        input logic [2:0] ex);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_addr = a;
        req_pattern = p;
        @(negedge ref_clk);
        req_valid = 1'b0;
        check({sel_c_b, sel_boot_b, sel_a_b}, es);
        check(req_err, ee);
        if (!ee) begin
            check(flash_addr, a[23:0]);
            check({ext_c, ext_b, ext_a}, ex);
            repeat (3) @(negedge ref_clk);
            check(req_ack, 1'b1);
            check({sel_c_b, sel_boot_b, sel_a_b}, 3'h7);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_probe_all;
        int n;
        do_reset(1'b0, 3'h7, n);
        check(n, 16);
        check(present_map, 3'h7);
        check(boot_fail, 1'b0);
    endtask

    // Image addresses kept inside one window, never across a boundary
    task automatic t_decode;
        do_req(32'hf9000000, 1'b0, 3'b101, 1'b0, 3'h0);
        do_req(32'hfaffffff, 1'b0, 3'b110, 1'b0, 3'h0);
        do_req(32'hf8123456, 1'b0, 3'b011, 1'b0, 3'h0);
        do_req(32'h10000000, 1'b0, 3'b111, 1'b1, 3'h0);
        do_req(32'h05000000, 1'b0, 3'b111, 1'b1, 3'h0);
        do_req(32'hf9240000, 1'b0, 3'b101, 1'b0, 3'h0);
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            op_mode = m[1:0];
            do_req(32'hfa000100, 1'b1, (m == 2) ? 3'b110 : 3'b111, m != 2, 3'h0);
            do_req(32'hf9000200, 1'b0, 3'b101, 1'b0, 3'h0);
        end
        op_mode = MODE_VIDEO;
    endtask

    task automatic t_missing_a;
        int n;
        do_reset(1'b0, 3'h6, n);
        check(present_map, 3'h6);
        check(ready, 1'b1);
        do_req(32'hfa000000, 1'b0, 3'b111, 1'b1, 3'h0);
        do_req(32'hf8000010, 1'b0, 3'b011, 1'b0, 3'h0);
    endtask

    // One large part: each image kept within a single block
    task automatic t_large;
        int n;
        do_reset(1'b1, 3'h2, n);
        check(ready, 1'b1);
        check(present_map, 3'h2);
        do_req(32'hfa000010, 1'b0, 3'b110, 1'b0, 3'h1);
        do_req(32'hf8abcdef, 1'b0, 3'b011, 1'b0, 3'h2);
        do_req(32'h03000000, 1'b0, 3'b101, 1'b0, 3'h3);
        do_req(32'h07ffffff, 1'b0, 3'b101, 1'b0, 3'h7);
        do_req(32'h08000000, 1'b0, 3'b111, 1'b1, 3'h7);
    endtask

    task automatic t_boot_fail;
        int n;
        do_reset(1'b0, 3'h5, n);
        check(boot_fail, 1'b1);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_addr = 32'hf8000000;
        repeat (20) @(negedge ref_clk);
        req_valid = 1'b0;
        check(ready, 1'b0);
        check({req_ack, req_err, sel_c_b, sel_boot_b, sel_a_b}, 5'h07);
    endtask

    initial begin
        t_probe_all();
        t_decode();
        t_modes();
        t_missing_a();
        t_large();
        t_boot_fail();
        print_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
